// ---- phy_bmc_pkg.sv ----
// Constants and types for the basic mode control register block.
// Assumes one 10 MHz bus clock and an AHB-Lite master with word accesses.
package phy_bmc_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;

	// Control field positions
	localparam int RST_BIT = 15;
	localparam int LPBK_BIT = 14;
	localparam int SPEED_BIT = 13;
	localparam int AN_BIT = 12;
	localparam int PD_BIT = 11;
	localparam int ISO_BIT = 10;
	localparam int RESTART_BIT = 9;
	localparam int DUPLEX_BIT = 8;
	localparam int COLT_BIT = 7;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_KHZ = 10000;
	localparam int DEAD_TIME_US = 500;
	localparam int DEAD_CYCLES_DEF = DEAD_TIME_US * CLK_KHZ / 1000;
	localparam logic [4:0] SWRST_CYCLES = 5'h10;

	// ****************************************
	// Types
	// ****************************************
	typedef struct packed {
		logic loopback;
		logic speed_100;
		logic autoneg;
		logic power_down;
		logic isolate;
		logic full_duplex;
		logic col_test;
	} ctrl_t;

	localparam ctrl_t CTRL_RESET = '0;

	typedef enum logic {BUS_IDLE = 1'b0, BUS_PEND = 1'b1} bus_state_t;
endpackage : phy_bmc_pkg

// ---- phy_basic_mode_control.sv ----
// Basic mode control register of a 10/100 port, with an AHB-Lite slave.
// Assumes MII transmit/receive signals already run on hclk; pins are synced.
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ps
module phy_basic_mode_control #(
	parameter int DEAD_CYCLES = phy_bmc_pkg::DEAD_CYCLES_DEF // Loopback dead time
) (
	input wire logic hclk, // Bus clock, 10 MHz
	input wire logic hresetn, // Asynchronous reset, active low
	input wire logic hsel, // Slave select
	input wire logic [31:0] haddr, // Byte address
	input wire logic [1:0] htrans, // Transfer type
	input wire logic hwrite, // Write when high
	input wire logic [2:0] hsize, // Word only
	input wire logic [31:0] hwdata, // Write data
	input wire logic hready, // Bus ready
	output logic [31:0] hrdata, // Read data
	output logic hreadyout, // Slave ready
	output logic hresp, // Always OKAY
	input wire logic [2:0] strap_cfg, // {autoneg, speed_100, full_duplex} pins
	input wire logic power_down_pin_active_low, // Power-down pin
	input wire logic neg_started, // Negotiation engine has restarted
	input wire logic neg_speed_100, // Negotiated speed
	input wire logic neg_full_duplex, // Negotiated duplex
	input wire logic [3:0] mii_txd, // Transmit nibble from MAC
	input wire logic mii_tx_en, // Transmit enable from MAC
	input wire logic [3:0] line_rxd, // Receive nibble from line side
	input wire logic line_rx_dv, // Receive valid from line side
	input wire logic line_col, // Line collision
	output logic [3:0] mii_rxd, // Receive nibble to MAC
	output logic mii_rx_dv, // Receive valid to MAC
	output logic mii_col, // Collision to MAC
	output logic mii_oe, // Drives MII outputs when high
	output logic [3:0] line_txd, // Transmit nibble to line side
	output logic line_tx_en, // Transmit enable to line side
	output logic neg_restart, // Restart request to negotiation engine
	output logic speed_100, // Operating speed
	output logic full_duplex, // Operating duplex
	output logic power_down // Effective power down
);
	localparam int DW = 13;

	// Dead-time counter is DW bits wide; refuse a length it cannot hold
	if (DEAD_CYCLES < 1 || DEAD_CYCLES >= (1 << DW)) begin : bad_dead_len
		$error("DEAD_CYCLES out of range");
	end

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [2:0] strap_s1_q, strap_s2_q;
	logic pdpin_s1_q, pdpin_s2_q;

	// Straps and the power-down pin are asynchronous to hclk
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			strap_s1_q <= 3'h0;
			strap_s2_q <= 3'h0;
			pdpin_s1_q <= 1'b1;
			pdpin_s2_q <= 1'b1;
		end else begin
			strap_s1_q <= strap_cfg;
			strap_s2_q <= strap_s1_q;
			pdpin_s1_q <= power_down_pin_active_low;
			pdpin_s2_q <= pdpin_s1_q;
		end
	end

	// ****************************************
	// Bus slave
	// ****************************************
	phy_bmc_pkg::bus_state_t bus_q, bus_d;
	logic [7:0] addr_q, addr_d;
	logic write_q, write_d;
	logic [31:0] rdata_q, rdata_d;
	logic ready_q, ready_d;
	logic wr_ctrl;
	phy_bmc_pkg::ctrl_t ctrl_q, ctrl_d;
	logic restart_q, restart_d;
	logic [4:0] rst_cnt_q, rst_cnt_d;
	logic [DW-1:0] dead_q, dead_d;
	logic pd_eff;

	// Word view of a register; unmapped offsets read zero
	function automatic logic [31:0] read_word(input logic [7:0] a);
		if (a == phy_bmc_pkg::CTRL_OFS) begin
			read_word = {16'h0000, rst_cnt_q != 5'h00, ctrl_q.loopback, ctrl_q.speed_100,
				ctrl_q.autoneg, ctrl_q.power_down, ctrl_q.isolate, restart_q,
				ctrl_q.full_duplex, ctrl_q.col_test, 7'h00};
		end else if (a == phy_bmc_pkg::STAT_OFS) begin
			read_word = {27'h0000000, dead_q != '0, pd_eff, restart_q, speed_100,
				full_duplex};
		end else begin
			read_word = 32'h00000000;
		end
	endfunction : read_word

	// One wait state per transfer, so a read always sees the previous write
	always_comb begin
		bus_d = bus_q;
		addr_d = addr_q;
		write_d = write_q;
		rdata_d = rdata_q;
		ready_d = ready_q;
		if (bus_q == phy_bmc_pkg::BUS_PEND) begin
			if (!write_q)
				rdata_d = read_word(addr_q);
			ready_d = 1'b1;
			bus_d = phy_bmc_pkg::BUS_IDLE;
		end else if (hsel && htrans[1] && hready) begin
			addr_d = haddr[7:0];
			write_d = hwrite;
			ready_d = 1'b0;
			bus_d = phy_bmc_pkg::BUS_PEND;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_q <= phy_bmc_pkg::BUS_IDLE;
			addr_q <= 8'h00;
			write_q <= 1'b0;
			rdata_q <= 32'h00000000;
			ready_q <= 1'b1;
		end else begin
			bus_q <= bus_d;
			addr_q <= addr_d;
			write_q <= write_d;
			rdata_q <= rdata_d;
			ready_q <= ready_d;
		end
	end

	assign wr_ctrl = (bus_q == phy_bmc_pkg::BUS_PEND) && write_q
		&& (addr_q == phy_bmc_pkg::CTRL_OFS);

	// ****************************************
	// Control register
	// ****************************************
	// Hardware reset also runs the reset sequence so straps are loaded once synced
	always_comb begin
		ctrl_d = ctrl_q;
		restart_d = restart_q;
		rst_cnt_d = rst_cnt_q;
		if (neg_started)
			restart_d = 1'b0;
		if (rst_cnt_q != 5'h00) begin
			rst_cnt_d = rst_cnt_q - 5'h01;
			if (rst_cnt_q == 5'h01) begin
				ctrl_d = phy_bmc_pkg::CTRL_RESET;
				ctrl_d.autoneg = strap_s2_q[2];
				ctrl_d.speed_100 = strap_s2_q[1];
				ctrl_d.full_duplex = strap_s2_q[0];
				restart_d = 1'b0;
			end
		end else if (wr_ctrl) begin
			// Bits 6:0 are simply not stored
			ctrl_d.loopback = hwdata[phy_bmc_pkg::LPBK_BIT];
			ctrl_d.speed_100 = hwdata[phy_bmc_pkg::SPEED_BIT];
			ctrl_d.autoneg = hwdata[phy_bmc_pkg::AN_BIT];
			ctrl_d.power_down = hwdata[phy_bmc_pkg::PD_BIT];
			ctrl_d.isolate = hwdata[phy_bmc_pkg::ISO_BIT];
			ctrl_d.full_duplex = hwdata[phy_bmc_pkg::DUPLEX_BIT];
			ctrl_d.col_test = hwdata[phy_bmc_pkg::COLT_BIT];
			if (hwdata[phy_bmc_pkg::RST_BIT])
				rst_cnt_d = phy_bmc_pkg::SWRST_CYCLES;
			// Zero leaves a pending restart alone; set wins over completion
			if (hwdata[phy_bmc_pkg::RESTART_BIT] && hwdata[phy_bmc_pkg::AN_BIT])
				restart_d = 1'b1;
		end
		if (!pdpin_s2_q)
			ctrl_d.power_down = 1'b1;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q <= phy_bmc_pkg::CTRL_RESET;
			restart_q <= 1'b0;
			rst_cnt_q <= phy_bmc_pkg::SWRST_CYCLES;
		end else begin
			ctrl_q <= ctrl_d;
			restart_q <= restart_d;
			rst_cnt_q <= rst_cnt_d;
		end
	end

	assign pd_eff = ctrl_q.power_down | ~pdpin_s2_q;

	// ****************************************
	// Operating mode and data path
	// ****************************************
	logic spd_d, dup_d, pd_d, oe_d, rxdv_d, col_d, txen_d, nrst_d;
	logic [3:0] rxd_d, txd_d;
	logic spd_q, dup_q, pd_q, oe_q, rxdv_q, col_q, txen_q, nrst_q, lpbk_prev_q;
	logic [3:0] rxd_q, txd_q;

	// Collision follows transmit enable by one cycle: 100 ns, which meets 512
	// bit times at both speeds but is above 4 bit times at 100 Mb/s
	always_comb begin
		dead_d = dead_q;
		if (ctrl_q.loopback && !lpbk_prev_q)
			dead_d = DW'(DEAD_CYCLES);
		else if (dead_q != '0)
			dead_d = dead_q - DW'(1);
		spd_d = ctrl_q.autoneg ? neg_speed_100 : ctrl_q.speed_100;
		dup_d = ctrl_q.autoneg ? neg_full_duplex : ctrl_q.full_duplex;
		pd_d = pd_eff;
		nrst_d = restart_q && !pd_eff;
		oe_d = !ctrl_q.isolate && !pd_eff;
		rxd_d = 4'h0;
		rxdv_d = 1'b0;
		col_d = 1'b0;
		txd_d = 4'h0;
		txen_d = 1'b0;
		if (oe_d) begin
			if (ctrl_q.loopback) begin
				rxd_d = mii_txd;
				rxdv_d = mii_tx_en && (dead_d == '0);
			end else begin
				rxd_d = line_rxd;
				rxdv_d = line_rx_dv;
				txd_d = mii_txd;
				txen_d = mii_tx_en;
			end
			col_d = ctrl_q.col_test ? mii_tx_en : line_col;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dead_q <= '0;
			lpbk_prev_q <= 1'b0;
			{spd_q, dup_q, pd_q, oe_q, rxdv_q, col_q, txen_q, nrst_q} <= 8'h00;
			rxd_q <= 4'h0;
			txd_q <= 4'h0;
		end else begin
			dead_q <= dead_d;
			lpbk_prev_q <= ctrl_q.loopback;
			{spd_q, dup_q, pd_q, oe_q, rxdv_q, col_q, txen_q, nrst_q} <=
				{spd_d, dup_d, pd_d, oe_d, rxdv_d, col_d, txen_d, nrst_d};
			rxd_q <= rxd_d;
			txd_q <= txd_d;
		end
	end

	assign hrdata = rdata_q;
	assign hreadyout = ready_q;
	assign hresp = 1'b0;
	assign mii_rxd = rxd_q;
	assign mii_rx_dv = rxdv_q;
	assign mii_col = col_q;
	assign mii_oe = oe_q;
	assign line_txd = txd_q;
	assign line_tx_en = txen_q;
	assign neg_restart = nrst_q;
	assign speed_100 = spd_q;
	assign full_duplex = dup_q;
	assign power_down = pd_q;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	reserved_read_a: assert property ((bus_q == phy_bmc_pkg::BUS_PEND) && !write_q
		&& addr_q == phy_bmc_pkg::CTRL_OFS |=> hrdata[6:0] == 7'h00)
		else $error("reserved bits read nonzero");
	swrst_busy_a: assert property (wr_ctrl && hwdata[15] && rst_cnt_q == 5'h00
		|=> rst_cnt_q == phy_bmc_pkg::SWRST_CYCLES)
		else $error("software reset not started");
	restart_ignore_a: assert property (wr_ctrl && !hwdata[12] && !restart_q
		&& rst_cnt_q == 5'h00 |=> !restart_q)
		else $error("restart taken with negotiation off");
	restart_hold_a: assert property (restart_q && !neg_started && rst_cnt_q == 5'h00
		|=> restart_q)
		else $error("restart cleared before start");
	pin_sets_pd_a: assert property (!pdpin_s2_q |=> ctrl_q.power_down ##1 power_down)
		else $error("pin did not set power down");
	forced_mode_a: assert property (!ctrl_q.autoneg |=> speed_100 == $past(ctrl_q.speed_100)
		&& full_duplex == $past(ctrl_q.full_duplex))
		else $error("forced mode not applied");
	loop_route_a: assert property (oe_q && $past(ctrl_q.loopback) |-> mii_rxd == $past(mii_txd)
		&& !line_tx_en)
		else $error("loopback data not routed");
	col_test_a: assert property (ctrl_q.col_test && mii_tx_en && oe_d |=> mii_col)
		else $error("collision test late");
	col_drop_a: assert property (ctrl_q.col_test && !mii_tx_en |=> !mii_col)
		else $error("collision test not dropped");
	dead_time_a: assert property (dead_q != '0 |-> !mii_rx_dv || !$past(ctrl_q.loopback))
		else $error("receive valid during dead time");
	isolate_a: assert property (ctrl_q.isolate |=> !mii_oe && !mii_rx_dv)
		else $error("isolate not applied");

	loopback_c: cover property (ctrl_q.loopback && dead_q == DW'(1));
	restart_c: cover property (restart_q ##1 neg_started ##1 !restart_q);
	swrst_c: cover property (rst_cnt_q == 5'h01 && strap_s2_q[2]);
endmodule : phy_basic_mode_control

// ---- neg_engine_model.sv ----
// Stand-in for the negotiation engine that answers the restart request.
// Assumes it shares hclk with the block; lag sets how slowly it answers.
`timescale 1ns/1ps
module neg_engine_model (
	input wire logic hclk, // Clock
	input wire logic hresetn, // Reset, active low
	input wire logic neg_restart, // Restart request
	input wire logic [7:0] lag, // Cycles before start
	output logic neg_started // Start pulse
);
	// ****************
	// Start sequencing
	// ****************
	logic [7:0] cnt_d, cnt_q;
	logic go_d;
	// Count while a restart pends; one pulse ends it, so a held request restarts the count
	always_comb begin
		go_d = neg_restart && !neg_started && cnt_q == lag;
		cnt_d = (neg_restart && !neg_started && cnt_q != lag) ? cnt_q + 8'h01 : 8'h00;
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= 8'h00;
			neg_started <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			neg_started <= go_d;
		end
	end
endmodule : neg_engine_model

// ---- phy_basic_mode_control_test.sv ----
// Self-checking bench for the basic mode control register block.
// Assumes a single AHB-Lite master whose hready is the slave's hreadyout.
`timescale 1ns/1ps
module phy_basic_mode_control_test;
	// ****************
	// Signals
	// ****************
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
	logic [1:0] htrans = 2'b00;
	logic [2:0] hsize = 3'b010, strap_cfg = 3'b101;
	logic power_down_pin_active_low = 1'b1, neg_started, neg_speed_100 = 1'b0;
	logic neg_full_duplex = 1'b0, mii_tx_en = 1'b0, line_rx_dv = 1'b0, line_col = 1'b0;
	logic [3:0] mii_txd = '0, line_rxd = '0, mii_rxd, line_txd;
	logic mii_rx_dv, mii_col, mii_oe, line_tx_en, neg_restart, speed_100, full_duplex;
	logic power_down;
	logic [7:0] lag = 8'h02;
	logic [15:0] m; // Expected control value
	logic [3:0] t;
	int fails = 0, checked = 0, cyc = 0;
	assign hready = hreadyout;
	always #50 hclk = ~hclk;
	phy_basic_mode_control #(.DEAD_CYCLES(20)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.strap_cfg(strap_cfg), .power_down_pin_active_low(power_down_pin_active_low),
		.neg_started(neg_started), .neg_speed_100(neg_speed_100),
		.neg_full_duplex(neg_full_duplex), .mii_txd(mii_txd), .mii_tx_en(mii_tx_en),
		.line_rxd(line_rxd), .line_rx_dv(line_rx_dv), .line_col(line_col), .mii_rxd(mii_rxd),
		.mii_rx_dv(mii_rx_dv), .mii_col(mii_col), .mii_oe(mii_oe), .line_txd(line_txd),
		.line_tx_en(line_tx_en), .neg_restart(neg_restart), .speed_100(speed_100),
		.full_duplex(full_duplex), .power_down(power_down));
	neg_engine_model partner (.hclk(hclk), .hresetn(hresetn), .neg_restart(neg_restart),
		.lag(lag), .neg_started(neg_started));
	// ****************
	// Tasks
	// ****************
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// Address phase held until hready, then data phase held until hready again
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= wr;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		r = hrdata;
	endtask : bus
	task automatic rdc(input logic [31:0] a, input logic [15:0] e);
		bus(1'b0, a, 32'h0);
		chk("read", {16'h0, e}, r);
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask : rdc
	// Poll until the reset bit drops; the global timeout bounds a hang
	task automatic wait_rst();
		do bus(1'b0, 32'h0, 32'h0); while (r[15] !== 1'b0);
	endtask : wait_rst
	task automatic wrap_up();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up
	// Cycle ceiling well above the few hundred cycles the run needs
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			wrap_up();
		end
	end
	// ****************
	// Scenarios
	// ****************
	initial begin
		void'($urandom(32'h3df4));
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		wait_rst();
		rdc(32'h0, 16'h1100);
		bus(1'b1, 32'h0, 32'hffff_007f & 32'h0000_007f);
		rdc(32'h0, 16'h0000);
		rdc(32'h8, 16'h0000);
		// Forced mode, all four speed and duplex combinations
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, 32'h0, {18'h0, i[1], 4'h0, i[0], 8'h0});
			repeat (3) @(posedge hclk);
			chk("speed", {31'h0, i[1]}, {31'h0, speed_100});
			chk("duplex", {31'h0, i[0]}, {31'h0, full_duplex});
			m = {2'b00, i[1], 4'h0, i[0], 8'h00};
			rdc(32'h0, m);
		end
		// Negotiated mode must ignore the forced bits
		neg_speed_100 <= 1'($urandom);
		neg_full_duplex <= 1'($urandom);
		@(posedge hclk);
		bus(1'b1, 32'h0, {18'h0, !neg_speed_100, 4'h8, !neg_full_duplex, 8'h0});
		repeat (3) @(posedge hclk);
		chk("speed", {31'h0, neg_speed_100}, {31'h0, speed_100});
		chk("duplex", {31'h0, neg_full_duplex}, {31'h0, full_duplex});
		bus(1'b1, 32'h0, 32'h0200);
		rdc(32'h0, 16'h0000);
		chk("restart", 32'h0, {31'h0, neg_restart});
		// Slow partner keeps the restart pending long enough to try clearing it
		lag <= 8'd30;
		bus(1'b1, 32'h0, 32'h1200);
		rdc(32'h0, 16'h1200);
		bus(1'b1, 32'h0, 32'h1000);
		rdc(32'h0, 16'h1200);
		for (int i = 0; i < 60 && neg_started !== 1'b1; i++) @(posedge hclk);
		repeat (3) @(posedge hclk);
		rdc(32'h0, 16'h1000);
		bus(1'b1, 32'h0, 32'h0080);
		t = 4'($urandom);
		mii_txd <= t;
		mii_tx_en <= 1'b1;
		repeat (2) @(posedge hclk);
		chk("col", 32'h1, {31'h0, mii_col});
		chk("line_txd", {28'h0, t}, {28'h0, line_txd});
		chk("line_tx_en", 32'h1, {31'h0, line_tx_en});
		mii_tx_en <= 1'b0;
		repeat (2) @(posedge hclk);
		chk("col", 32'h0, {31'h0, mii_col});
		// Loopback: dead time first, then transmit data returns on receive
		bus(1'b1, 32'h0, 32'h4000);
		mii_tx_en <= 1'b1;
		repeat (15) begin
			@(posedge hclk);
			chk("rx_dv", 32'h0, {31'h0, mii_rx_dv});
		end
		repeat (20) @(posedge hclk);
		repeat (8) begin
			t = 4'($urandom);
			mii_txd <= t;
			line_rxd <= ~t;
			repeat (2) @(posedge hclk);
			chk("rxd", {28'h0, t}, {28'h0, mii_rxd});
			chk("tx_en", 32'h0, {31'h0, line_tx_en});
			chk("rx_dv", 32'h1, {31'h0, mii_rx_dv});
		end
		mii_tx_en <= 1'b0;
		bus(1'b1, 32'h0, 32'h0400);
		repeat (2) @(posedge hclk);
		chk("oe", 32'h0, {31'h0, mii_oe});
		rdc(32'h0, 16'h0400);
		bus(1'b1, 32'h0, 32'h0);
		power_down_pin_active_low <= 1'b0;
		repeat (6) @(posedge hclk);
		chk("pd", 32'h1, {31'h0, power_down});
		chk("oe", 32'h0, {31'h0, mii_oe});
		power_down_pin_active_low <= 1'b1;
		rdc(32'h0, 16'h0800);
		// Software reset must re-sample changed straps
		strap_cfg <= 3'b010;
		bus(1'b1, 32'h0, 32'h8000);
		bus(1'b0, 32'h0, 32'h0);
		chk("reset", 32'h1, {31'h0, r[15]});
		wait_rst();
		rdc(32'h0, 16'h2000);
		wrap_up();
	end
endmodule : phy_basic_mode_control_test
